// ===== mrm_pkg.sv
/*
  Package for the metering register bank: register indices, widths,
  reset values and the signal-path structs.
  Assumes a single 32-bit AXI4-Lite slave; byte address = 4 * index.
*/
package mrm_pkg;

  localparam int unsigned MRM_AW = 18;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] IDX_NEUTRAL_I = 16'hE50F;
  localparam logic [15:0] IDX_VB = 16'hE510;
  localparam logic [15:0] IDX_VC = 16'hE512;
  localparam logic [15:0] IDX_PWR_A = 16'hE513;
  localparam logic [15:0] IDX_PWR_B = 16'hE514;
  localparam logic [15:0] IDX_PWR_C = 16'hE515;
  localparam logic [15:0] IDX_RSV_LO = 16'hE516;
  localparam logic [15:0] IDX_RSV_HI = 16'hE518;
  localparam logic [15:0] IDX_VA_A = 16'hE519;
  localparam logic [15:0] IDX_VA_B = 16'hE51A;
  localparam logic [15:0] IDX_VA_C = 16'hE51B;
  localparam logic [15:0] IDX_CHECKSUM = 16'hE51F;
  localparam logic [15:0] IDX_NOMINAL_VOLTAGE_RMS = 16'hE520;
  localparam logic [15:0] IDX_LAST32 = 16'hE5FF;
  localparam logic [15:0] IDX_PEAK = 16'hE600;
  localparam logic [15:0] IDX_DLY0 = 16'hE601;
  localparam logic [15:0] IDX_DLY1 = 16'hE602;
  localparam logic [15:0] IDX_DLY2 = 16'hE603;
  localparam logic [15:0] IDX_IDLE = 16'hE608;
  localparam logic [15:0] IDX_ACCUMULATION_CYCLE_COUNT = 16'hE60C;
  localparam logic [15:0] IDX_ZXTO = 16'hE60D;
  localparam logic [15:0] IDX_COMP = 16'hE60E;
  localparam logic [15:0] IDX_GAIN = 16'hE60F;
  localparam logic [15:0] IDX_PULSE = 16'hE610;
  localparam logic [15:0] IDX_DEN1 = 16'hE611;
  localparam logic [15:0] IDX_DEN2 = 16'hE612;
  localparam logic [15:0] IDX_DEN3 = 16'hE613;
  localparam logic [15:0] IDX_TRIM_A = 16'hE614;
  localparam logic [15:0] IDX_TRIM_B = 16'hE615;
  localparam logic [15:0] IDX_TRIM_C = 16'hE616;
  localparam logic [15:0] IDX_SIGN = 16'hE617;
  localparam logic [15:0] IDX_SETUP = 16'hE618;
  localparam logic [15:0] IDX_MEAS = 16'hE700;
  localparam logic [15:0] IDX_ACC = 16'hE701;

  localparam logic [31:0] RST_CHECKSUM = 32'hAFFA63B9;
  localparam logic [23:0] RST_NOMINAL_VOLTAGE_RMS = 24'h000000;
  localparam logic [15:0] RST_ACCUMULATION_CYCLE_COUNT = 16'hFFFF;
  localparam logic [15:0] RST_ZXTO = 16'hFFFF;
  localparam logic [15:0] RST_COMP = 16'h01FF;
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [15:0] RST_PULSE = 16'h0EA0;
  localparam logic [15:0] RST_DEN = 16'h0000;
  localparam logic [9:0] RST_TRIM = 10'h000;
  localparam logic [15:0] RST_SETUP = 16'h0002;
  localparam logic [7:0] RST_MEAS = 8'h1C;
  localparam logic [7:0] RST_ACC = 8'h80;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // measurement values delivered by the signal path
  typedef struct packed {
    logic [23:0] neutral_current_sample;
    logic [23:0] phase_a_voltage_sample;
    logic [23:0] phase_b_voltage_sample;
    logic [23:0] phase_c_voltage_sample;
    logic [23:0] phase_a_active_power_now;
    logic [23:0] phase_b_active_power_now;
    logic [23:0] phase_c_active_power_now;
    logic [23:0] phase_a_apparent_power_now;
    logic [23:0] phase_b_apparent_power_now;
    logic [23:0] phase_c_apparent_power_now;
    logic [15:0] phase_peak_flags;
    logic [15:0] interphase_delay_0;
    logic [15:0] interphase_delay_1;
    logic [15:0] interphase_delay_2;
    logic [15:0] idle_phase_flags;
    logic [15:0] power_sign_flags;
  } mrm_meas_s;

  // configuration handed to the signal path
  typedef struct packed {
    logic [23:0] nominal_voltage_rms;
    logic [15:0] accumulation_cycle_count;
    logic [15:0] crossing_timeout_count;
    logic [15:0] computation_select;
    logic [15:0] input_gain_select;
    logic [15:0] pulse_output_setup;
    logic [15:0] pulse_one_divisor;
    logic [15:0] pulse_two_divisor;
    logic [15:0] pulse_three_divisor;
    logic [9:0] phase_a_delay_trim;
    logic [9:0] phase_b_delay_trim;
    logic [9:0] phase_c_delay_trim;
    logic [15:0] device_setup;
    logic [7:0] measurement_select;
    logic [7:0] accumulation_select;
  } mrm_cfg_s;

endpackage

// ===== mrm_regs.sv
/*
  Metering register bank behind an AXI4-Lite slave.
  Assumes measurement inputs come from logic on core_clk_i (no sync),
  and a master with at most one write and one read outstanding.
*/
// Behaviour
// - last_wide_transfer_copy holds data of the latest good 32-bit transfer.
// - read-only 32-bit checksum reads AFFA63B9 after reset.
// - writable signed 24-bit nominal voltage, zero at reset, zero-padded.
// - writable 16-bit line-cycle count, FFFF at reset.
// - writable 16-bit computation-mode register, resets to 01FF.
// - writable 16-bit pulse-output setup register, resets to 0EA0.
// - writable 8-bit measurement mode register, resets to 1C.
// - writable 16-bit amplifier gain select, zero at reset.
// - per-phase writable 10-bit delay trim, zero at reset, zero-padded.
// - three read-only 16-bit interphase delay measurements.
// - phase voltage samples read as 24-bit signed, sign-extended.
// - neutral current sample is not readable; its slot returns the phase A voltage sample.
// - per-phase active power reads as 24-bit signed, sign-extended.
// - per-phase apparent power reads as 24-bit signed, sign-extended.
// - read-only 16-bit register of phases without load.
// - read-only 16-bit register of phases with peak events.
// - read-only 16-bit register of power signs per phase.
// - signed values kept in two's complement, unsigned as plain binary.
`timescale 1ns/1ps
`default_nettype none
module mrm_regs
  import mrm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [MRM_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [MRM_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire mrm_meas_s meas_i,
  output mrm_cfg_s cfg_o
);

  // sign-extension of a 24-bit two's complement value
  function automatic logic [31:0] sext24(input logic [23:0] v);
    sext24 = {{8{v[23]}}, v};
  endfunction

  function automatic logic [31:0] zpad16(input logic [15:0] v);
    zpad16 = {16'h0000, v};
  endfunction

  // byte-lane merge for a write into a register of any width up to 32
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  logic aw_held_r;
  logic w_held_r;
  logic [15:0] aw_idx_r;
  logic aw_lsb_ok_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  mrm_cfg_s cfg_r;
  logic [31:0] last32_r;

  logic do_write;
  logic wr_ok;
  logic wr_wide;
  logic [31:0] wr_merged;
  logic [31:0] wr_old;
  logic [31:0] rd_val;
  logic rd_ok;
  logic rd_wide;
  logic [15:0] ar_idx;

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  assign cfg_o = cfg_r;

  // address and data may arrive in either order; each is held until both
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      aw_held_r <= 1'b0;
      aw_idx_r <= 16'h0000;
      aw_lsb_ok_r <= 1'b0;
      s_axi_awready_o <= 1'b1;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_held_r <= 1'b1;
      aw_idx_r <= s_axi_awaddr_i[17:2];
      aw_lsb_ok_r <= (s_axi_awaddr_i[1:0] == 2'b00);
      s_axi_awready_o <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held_r <= 1'b0;
    end
    else if (bvalid_r && s_axi_bready_i)
      s_axi_awready_o <= 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_wready_o <= 1'b1;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata_i;
      wstrb_r <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end
    else if (do_write)
    begin
      w_held_r <= 1'b0;
    end
    else if (bvalid_r && s_axi_bready_i)
      s_axi_wready_o <= 1'b1;
  end

  assign do_write = aw_held_r & w_held_r & ~bvalid_r;

  // write decode: old value, legality, and whether the transfer is 32 bits
  always_comb
  begin
    wr_old = 32'h00000000;
    wr_ok = 1'b1;
    wr_wide = 1'b0;
    unique case (aw_idx_r)
      IDX_NOMINAL_VOLTAGE_RMS:
      begin
        wr_old = {8'h00, cfg_r.nominal_voltage_rms};
        wr_wide = 1'b1;
      end
      IDX_ACCUMULATION_CYCLE_COUNT: wr_old = zpad16(cfg_r.accumulation_cycle_count);
      IDX_ZXTO: wr_old = zpad16(cfg_r.crossing_timeout_count);
      IDX_COMP: wr_old = zpad16(cfg_r.computation_select);
      IDX_GAIN: wr_old = zpad16(cfg_r.input_gain_select);
      IDX_PULSE: wr_old = zpad16(cfg_r.pulse_output_setup);
      IDX_DEN1: wr_old = zpad16(cfg_r.pulse_one_divisor);
      IDX_DEN2: wr_old = zpad16(cfg_r.pulse_two_divisor);
      IDX_DEN3: wr_old = zpad16(cfg_r.pulse_three_divisor);
      IDX_TRIM_A: wr_old = {22'h0, cfg_r.phase_a_delay_trim};
      IDX_TRIM_B: wr_old = {22'h0, cfg_r.phase_b_delay_trim};
      IDX_TRIM_C: wr_old = {22'h0, cfg_r.phase_c_delay_trim};
      IDX_SETUP: wr_old = zpad16(cfg_r.device_setup);
      IDX_MEAS: wr_old = {24'h000000, cfg_r.measurement_select};
      IDX_ACC: wr_old = {24'h000000, cfg_r.accumulation_select};
      default: wr_ok = 1'b0;
    endcase
    if (!aw_lsb_ok_r)
    begin
      wr_ok = 1'b0;
    end
  end

  assign wr_merged = merge(wr_old, wdata_r, wstrb_r);

  // a write to the shared sample slot falls to the error default
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_r.nominal_voltage_rms <= RST_NOMINAL_VOLTAGE_RMS;
      cfg_r.accumulation_cycle_count <= RST_ACCUMULATION_CYCLE_COUNT;
      cfg_r.crossing_timeout_count <= RST_ZXTO;
      cfg_r.computation_select <= RST_COMP;
      cfg_r.input_gain_select <= RST_GAIN;
      cfg_r.pulse_output_setup <= RST_PULSE;
      cfg_r.pulse_one_divisor <= RST_DEN;
      cfg_r.pulse_two_divisor <= RST_DEN;
      cfg_r.pulse_three_divisor <= RST_DEN;
      cfg_r.phase_a_delay_trim <= RST_TRIM;
      cfg_r.phase_b_delay_trim <= RST_TRIM;
      cfg_r.phase_c_delay_trim <= RST_TRIM;
      cfg_r.device_setup <= RST_SETUP;
      cfg_r.measurement_select <= RST_MEAS;
      cfg_r.accumulation_select <= RST_ACC;
    end
    else if (do_write && wr_ok)
    begin
      unique case (aw_idx_r)
        IDX_NOMINAL_VOLTAGE_RMS: cfg_r.nominal_voltage_rms <= wr_merged[23:0];
        IDX_ACCUMULATION_CYCLE_COUNT: cfg_r.accumulation_cycle_count <= wr_merged[15:0];
        IDX_ZXTO: cfg_r.crossing_timeout_count <= wr_merged[15:0];
        IDX_COMP: cfg_r.computation_select <= wr_merged[15:0];
        IDX_GAIN: cfg_r.input_gain_select <= wr_merged[15:0];
        IDX_PULSE: cfg_r.pulse_output_setup <= wr_merged[15:0];
        IDX_DEN1: cfg_r.pulse_one_divisor <= wr_merged[15:0];
        IDX_DEN2: cfg_r.pulse_two_divisor <= wr_merged[15:0];
        IDX_DEN3: cfg_r.pulse_three_divisor <= wr_merged[15:0];
        IDX_TRIM_A: cfg_r.phase_a_delay_trim <= wr_merged[9:0];
        IDX_TRIM_B: cfg_r.phase_b_delay_trim <= wr_merged[9:0];
        IDX_TRIM_C: cfg_r.phase_c_delay_trim <= wr_merged[9:0];
        IDX_SETUP: cfg_r.device_setup <= wr_merged[15:0];
        IDX_MEAS: cfg_r.measurement_select <= wr_merged[7:0];
        IDX_ACC: cfg_r.accumulation_select <= wr_merged[7:0];
        default: cfg_r.device_setup <= cfg_r.device_setup;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      bvalid_r <= 1'b0;
    end
  end

  assign ar_idx = s_axi_araddr_i[17:2];

  // read decode; reserved power slots read zero
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_ok = (s_axi_araddr_i[1:0] == 2'b00);
    rd_wide = 1'b0;
    unique case (ar_idx)
      IDX_NEUTRAL_I:
      begin
        // the slot is shared; the voltage sample takes the read
        rd_val = sext24(meas_i.phase_a_voltage_sample);
        rd_wide = 1'b1;
      end
      IDX_VB:
      begin
        rd_val = sext24(meas_i.phase_b_voltage_sample);
        rd_wide = 1'b1;
      end
      IDX_VC:
      begin
        rd_val = sext24(meas_i.phase_c_voltage_sample);
        rd_wide = 1'b1;
      end
      IDX_PWR_A:
      begin
        rd_val = sext24(meas_i.phase_a_active_power_now);
        rd_wide = 1'b1;
      end
      IDX_PWR_B:
      begin
        rd_val = sext24(meas_i.phase_b_active_power_now);
        rd_wide = 1'b1;
      end
      IDX_PWR_C:
      begin
        rd_val = sext24(meas_i.phase_c_active_power_now);
        rd_wide = 1'b1;
      end
      IDX_VA_A:
      begin
        rd_val = sext24(meas_i.phase_a_apparent_power_now);
        rd_wide = 1'b1;
      end
      IDX_VA_B:
      begin
        rd_val = sext24(meas_i.phase_b_apparent_power_now);
        rd_wide = 1'b1;
      end
      IDX_VA_C:
      begin
        rd_val = sext24(meas_i.phase_c_apparent_power_now);
        rd_wide = 1'b1;
      end
      IDX_CHECKSUM:
      begin
        rd_val = RST_CHECKSUM;
        rd_wide = 1'b1;
      end
      IDX_NOMINAL_VOLTAGE_RMS:
      begin
        rd_val = {8'h00, cfg_r.nominal_voltage_rms};
        rd_wide = 1'b1;
      end
      IDX_LAST32: rd_val = last32_r;
      IDX_PEAK: rd_val = zpad16(meas_i.phase_peak_flags);
      IDX_DLY0: rd_val = zpad16(meas_i.interphase_delay_0);
      IDX_DLY1: rd_val = zpad16(meas_i.interphase_delay_1);
      IDX_DLY2: rd_val = zpad16(meas_i.interphase_delay_2);
      IDX_IDLE: rd_val = zpad16(meas_i.idle_phase_flags);
      IDX_ACCUMULATION_CYCLE_COUNT: rd_val = zpad16(cfg_r.accumulation_cycle_count);
      IDX_ZXTO: rd_val = zpad16(cfg_r.crossing_timeout_count);
      IDX_COMP: rd_val = zpad16(cfg_r.computation_select);
      IDX_GAIN: rd_val = zpad16(cfg_r.input_gain_select);
      IDX_PULSE: rd_val = zpad16(cfg_r.pulse_output_setup);
      IDX_DEN1: rd_val = zpad16(cfg_r.pulse_one_divisor);
      IDX_DEN2: rd_val = zpad16(cfg_r.pulse_two_divisor);
      IDX_DEN3: rd_val = zpad16(cfg_r.pulse_three_divisor);
      IDX_TRIM_A: rd_val = {22'h0, cfg_r.phase_a_delay_trim};
      IDX_TRIM_B: rd_val = {22'h0, cfg_r.phase_b_delay_trim};
      IDX_TRIM_C: rd_val = {22'h0, cfg_r.phase_c_delay_trim};
      IDX_SIGN: rd_val = zpad16(meas_i.power_sign_flags);
      IDX_SETUP: rd_val = zpad16(cfg_r.device_setup);
      IDX_MEAS: rd_val = {24'h000000, cfg_r.measurement_select};
      IDX_ACC: rd_val = {24'h000000, cfg_r.accumulation_select};
      default:
      begin
        if (ar_idx >= IDX_RSV_LO && ar_idx <= IDX_RSV_HI)
        begin
          rd_wide = 1'b1;
        end
        else
        begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
      s_axi_arready_o <= 1'b1;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= rd_ok ? rd_val : 32'h00000000;
      s_axi_arready_o <= 1'b0;
    end
    else if (s_axi_rready_i)
    begin
      rvalid_r <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // a read and a write finishing together: the write is taken as later
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      last32_r <= 32'h00000000;
    end
    else if (do_write && wr_ok && wr_wide)
    begin
      last32_r <= {8'h00, wr_merged[23:0]};
    end
    else if (s_axi_arvalid_i && s_axi_arready_o && rd_ok && rd_wide)
    begin
      last32_r <= rd_val;
    end
  end

endmodule
`default_nettype wire

// ===== mrm_regs_sva.sv
/*
  Checker for the metering register bank: handshakes, read shaping,
  config writes. Assumes a bind to mrm_regs; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mrm_regs_sva
  import mrm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [MRM_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [MRM_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire mrm_meas_s meas_i,
  input wire mrm_cfg_s cfg_o
);
  logic rd_go;
  logic aw_go;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  assign aw_go = s_axi_awvalid_i && s_axi_awready_o;
  read_turn_a: assert property (rd_go |=> s_axi_rvalid_o)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer not held");
  write_turn_a: assert property (aw_go && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
  write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp not held");
  read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("address taken while answer pending");
  cfg_quiet_a: assert property (!s_axi_bvalid_o |-> $stable(cfg_o))
    else $error("config changed without a write");
  sum_read_a: assert property (rd_go &&
    s_axi_araddr_i == {IDX_CHECKSUM, 2'b00} |=>
    s_axi_rdata_o == RST_CHECKSUM && s_axi_rresp_o == RESP_OKAY)
    else $error("checksum read wrong");
  sum_locked_a: assert property (aw_go &&
    s_axi_awaddr_i == {IDX_CHECKSUM, 2'b00} |-> ##[1:8]
    (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR))
    else $error("checksum write not refused");
  sign_fill_a: assert property (rd_go &&
    s_axi_araddr_i == {IDX_VB, 2'b00} |=> s_axi_rdata_o ==
    {{8{$past(meas_i.phase_b_voltage_sample[23])}},
    $past(meas_i.phase_b_voltage_sample)}) else $error("sign fill wrong");
  zero_fill_a: assert property (rd_go &&
    s_axi_araddr_i == {IDX_TRIM_A, 2'b00} |=>
    s_axi_rdata_o == {22'h0, $past(cfg_o.phase_a_delay_trim)})
    else $error("zero fill wrong");
endmodule
bind mrm_regs mrm_regs_sva u_mrm_regs_sva (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .meas_i(meas_i), .cfg_o(cfg_o));
`default_nettype wire

// ===== test_metering_register_map_e5_e7.sv
/*
  Bench for mrm_regs: reset values, read-back, sample shaping, refusals.
  Assumes mrm_pkg and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_metering_register_map_e5_e7
  import mrm_pkg::*;
;
  localparam logic [15:0] WIDX [15] = '{IDX_NOMINAL_VOLTAGE_RMS, IDX_ACCUMULATION_CYCLE_COUNT, IDX_ZXTO,
    IDX_COMP, IDX_GAIN, IDX_PULSE, IDX_DEN1, IDX_DEN2, IDX_DEN3,
    IDX_TRIM_A, IDX_TRIM_B, IDX_TRIM_C, IDX_SETUP, IDX_MEAS, IDX_ACC};
  localparam int WW [15] = '{24, 16, 16, 16, 16, 16, 16, 16, 16, 10, 10,
    10, 16, 8, 8};
  localparam logic [31:0] WRST [15] = '{32'h0, 32'hFFFF, 32'hFFFF,
    32'h1FF, 32'h0, 32'hEA0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h2, 32'h1C, 32'h80};
  localparam logic [15:0] RIDX [15] = '{IDX_NEUTRAL_I, IDX_VB, IDX_VC,
    IDX_PWR_A, IDX_PWR_B, IDX_PWR_C, IDX_VA_A, IDX_VA_B, IDX_VA_C,
    IDX_PEAK, IDX_DLY0, IDX_DLY1, IDX_DLY2, IDX_IDLE, IDX_SIGN};
  logic clk = 1'b0, rst = 1'b1;
  logic [MRM_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, got, exp;
  logic [3:0] wstrb = '0, be;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  mrm_meas_s meas = '0;
  mrm_cfg_s cfg;
  int error_cnt = 0, total_checks = 0, seed = 60, i, p;
  logic [23:0] m24 [10];
  logic [15:0] m16 [6];
  logic [31:0] mdl [15];

  mrm_regs u_mrm_regs (.core_clk_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .meas_i(meas),
    .cfg_o(cfg));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("CHECK FAILED at %0t: wait got %h exp %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: data got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: resp got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_cfg(input mrm_cfg_s g, input mrm_cfg_s e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: cfg got %h exp %h", $time, g, e);
    end
  endtask

  // the host side never writes to the reserved holes
  task automatic wr(input logic [15:0] idx, input logic [31:0] d,
    input logic [3:0] b, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= b;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      hang();
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      hang();
  endtask

  // strobed lanes replace old bytes; bits above the width read as zero
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] b, input int w);
    for (int k = 0; k < 4; k++)
      if (b[k])
        o[k*8 +: 8] = d[k*8 +: 8];
    return o & ((32'h1 << w) - 32'h1);
  endfunction

  // writable registers in the order the config output carries them
  function automatic mrm_cfg_s cfg_of();
    return {mdl[0][23:0], mdl[1][15:0], mdl[2][15:0], mdl[3][15:0],
      mdl[4][15:0], mdl[5][15:0], mdl[6][15:0], mdl[7][15:0],
      mdl[8][15:0], mdl[9][9:0], mdl[10][9:0], mdl[11][9:0],
      mdl[12][15:0], mdl[13][7:0], mdl[14][7:0]};
  endfunction

  task automatic chk_resets();
    for (i = 0; i < 15; i++)
    begin
      rd(WIDX[i], got, rs);
      chk_data(got, WRST[i]);
      mdl[i] = WRST[i];
    end
    chk_cfg(cfg, cfg_of());
    rd(IDX_CHECKSUM, got, rs);
    chk_data(got, 32'hAFFA63B9);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk_resets();
    $display("test reset values done");
    for (p = 0; p < 2; p++)
      for (i = 0; i < 15; i++)
      begin
        exp = $random(seed);
        got = $random(seed);
        be = p ? got[3:0] : 4'hF;
        wr(WIDX[i], exp, be, rs);
        chk_resp(rs, RESP_OKAY);
        mdl[i] = merge(mdl[i], exp, be, WW[i]);
        rd(WIDX[i], got, rs);
        chk_data(got, mdl[i]);
        chk_cfg(cfg, cfg_of());
        rd(IDX_LAST32, got, rs);
        chk_data(got, mdl[0]);
      end
    $display("test write read-back done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_resets();
    $display("test second reset done");
    for (p = 0; p < 4; p++)
    begin
      for (i = 0; i < 16; i++)
      begin
        got = $random(seed);
        if (i < 10)
          m24[i] = {(p < 2) ? p[0] : got[23], got[22:0]};
        else
          m16[i-10] = got[15:0];
      end
      @(posedge clk);
      meas <= {m24[0], m24[1], m24[2], m24[3], m24[4], m24[5], m24[6],
        m24[7], m24[8], m24[9], m16[0], m16[1], m16[2], m16[3], m16[4],
        m16[5]};
      for (i = 0; i < 15; i++)
      begin
        rd(RIDX[i], got, rs);
        exp = (i < 9) ? {{8{m24[i+1][23]}}, m24[i+1]} : {16'h0, m16[i-9]};
        chk_data(got, exp);
        rd(IDX_LAST32, got, rs);
        chk_data(got, (i < 9) ? exp : {{8{m24[9][23]}}, m24[9]});
      end
    end
    $display("test sample reads done");
    rd(IDX_CHECKSUM, got, rs);
    chk_data(got, RST_CHECKSUM);
    wr(IDX_PEAK, 32'h1234, 4'hF, rs);
    chk_resp(rs, RESP_SLVERR);
    wr(IDX_CHECKSUM, 32'h0, 4'hF, rs);
    chk_resp(rs, RESP_SLVERR);
    wr(IDX_NEUTRAL_I, 32'h0, 4'hF, rs);
    chk_resp(rs, RESP_SLVERR);
    rd(IDX_LAST32, got, rs);
    chk_data(got, 32'hAFFA63B9);
    rd(IDX_RSV_LO, got, rs);
    chk_data(got, 32'h0);
    rd(16'hE702, got, rs);
    chk_resp(rs, RESP_SLVERR);
    $display("test refusals done");
    complete_run();
  end
endmodule
`default_nettype wire
